/* src/tmr_pkg.sv */
// Purpose: Shared constants and types for the up-mode timer/counter
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: Offsets are byte addresses

package tmr_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CHCTL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] CHCMP_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] VEC_OFS = 8'h14;

  // Control register fields
  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 2;
  localparam int MODE_LSB = 4;
  localparam int CLR_BIT = 6;
  localparam int OVF_BIT = 7;

  // Channel control fields
  localparam int CAP_BIT = 0;
  localparam int CH0_FLAG_BIT = 1;
  localparam int CH1_FLAG_BIT = 2;

  // Vector codes
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_CH0 = 4'h2;
  localparam logic [3:0] VEC_CH1 = 4'h4;
  localparam logic [3:0] VEC_OVF = 4'hA;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_FULL = 4'hF;

  // Clock source codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_AUX = 2'h1;
  localparam logic [1:0] SRC_SUB = 2'h2;
  localparam logic [1:0] SRC_INV = 2'h3;

  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_UP = 2'b01,
    MODE_CONT = 2'b11
  } mode_t;
endpackage : tmr_pkg

/* src/tick_if.sv */
// Purpose: Carries source select, divider and tick between control and prescaler
// Assumes: Single clock domain
// Notes: Tick is a one-cycle enable

`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  logic [1:0] sel;
  logic [1:0] div;
  logic clr;
  logic tick;
  modport gen (input sel, input div, input clr, output tick);
  modport use_side (output sel, output div, output clr, input tick);
endinterface : tick_if

`default_nettype wire

/* src/tick_prescaler.sv */
// Purpose: Synchronises the four clock sources, picks one, divides its edges
// Assumes: Source pins toggle well below half of aclk
// Notes: Clear restarts the divider so the first count also waits the full ratio

`timescale 1ns/1ps
`default_nettype none

module tick_prescaler
  import tmr_pkg::*;
(
  // System
  input wire logic aclk,
  input wire logic aresetn,
  // Raw sources, indexed by source code
  input wire logic [3:0] src_pins,
  // Control side
  tick_if.gen tk
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] edge_w;
  logic [2:0] pre_r;
  logic [2:0] pre_lim;
  logic edge_sel;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
        end
        else
        begin
          s1_r[g] <= src_pins[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
      // The inverted source counts on the falling edge of its pin
      if (g == SRC_INV)
      begin : g_inv
        assign edge_w[g] = !s2_r[g] && s3_r[g];
      end
      else
      begin : g_pos
        assign edge_w[g] = s2_r[g] && !s3_r[g];
      end
    end
  endgenerate

  assign edge_sel = edge_w[tk.sel];
  assign pre_lim = 3'((4'h1 << tk.div) - 4'h1);
  assign tk.tick = edge_sel && (pre_r == pre_lim) && !tk.clr;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tk.clr)
      pre_r <= 3'h0;
    else if (edge_sel)
      pre_r <= (pre_r == pre_lim) ? 3'h0 : pre_r + 3'h1;
  end
endmodule : tick_prescaler

`default_nettype wire

/* src/up_mode_timer_counter.sv */
// Purpose: Timer/counter with period compare, one capture/compare channel, vector
// Assumes: AXI4-Lite slave at 25 MHz; source pins are asynchronous
// Notes: Flags are sticky; hardware set wins over a software or vector-read flag clear in the same cycle
//
// What this block does
// - In up mode the overflow flag rises only on the wrap to zero from a count at or above the period value.
// - Writing the clear bit forces the counter to zero even when stopped at the period.
// - In compare mode a count that lands on the channel value flags, also after a +1 edit.
// - The counter clock is one of inverted external input, subsystem, aux or pin clock.
// - Each increment, the first after a clear included, waits the full input divider ratio.
// - Power-on reset and the clear bit both zero the counter and counting restarts at zero.
// - A full-word write to the control register also clears the interrupt vector.
// - A watchdog power-up clear puts control and vector back to reset state in any case.
// - The channel switches between capture and compare; equality flags only in compare.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module up_mode_timer_counter
  import tmr_pkg::*;
#(
  parameter int WIDTH = tmr_pkg::CNT_W
)
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_up_clear,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [tmr_pkg::ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [tmr_pkg::ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Clock source and capture pins
  input wire logic inverted_ext_clock,
  input wire logic subsystem_clock,
  input wire logic aux_clock,
  input wire logic ext_timer_clock,
  input wire logic capture_in,
  // Counter state
  output logic [WIDTH-1:0] counter_value
);
  import tmr_pkg::*;

  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
                                             input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{(32-WIDTH){1'b0}}, old};
    for (int i = 0; i < 4; i++)
      if (s[i])
        m[8*i +: 8] = d[8*i +: 8];
    return m[WIDTH-1:0];
  endfunction : merge

  tick_if tk ();

  // Bus state
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  // Timer state
  logic [7:0] ctrl_r;
  logic [WIDTH-1:0] cnt_r, cnt_nxt, period_r, ccr_r;
  logic cap_mode_r, ovf_r, ch0_r, ch1_r;
  logic [2:0] cap_sync_r;

  // Write decode
  logic do_wr, wr_ctrl, wr_period, wr_chctl, wr_chcmp, wr_hit;
  logic [7:0] ctrl_wv;
  logic [2:0] chctl_wv;
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_ctrl = do_wr && awaddr_r == CTRL_OFS;
  assign wr_period = do_wr && awaddr_r == PERIOD_OFS;
  assign wr_chctl = do_wr && awaddr_r == CHCTL_OFS;
  assign wr_chcmp = do_wr && awaddr_r == CHCMP_OFS;
  assign wr_hit = awaddr_r == CTRL_OFS || awaddr_r == CNT_OFS || awaddr_r == PERIOD_OFS
               || awaddr_r == CHCTL_OFS || awaddr_r == CHCMP_OFS || awaddr_r == VEC_OFS;
  assign ctrl_wv = wstrb_r[0] ? wdata_r[7:0] : ctrl_r;
  assign chctl_wv = wstrb_r[0] ? wdata_r[2:0] : {ch1_r, ch0_r, cap_mode_r};

  // Read decode
  logic rd_take, rd_vec;
  logic [3:0] vec_w;
  logic [WIDTH-1:0] rd_val;
  assign rd_take = arvalid && !rvalid_r;
  assign rd_vec = rd_take && araddr == VEC_OFS;
  assign vec_w = ch0_r ? VEC_CH0 : ch1_r ? VEC_CH1 : ovf_r ? VEC_OVF : VEC_NONE;
  // The overflow flag lives in its own flop; the stored control bit 7 is always zero
  assign rd_val = (araddr == CTRL_OFS) ? WIDTH'({ovf_r, 1'b0, ctrl_r[5:0]})
                : (araddr == CNT_OFS) ? cnt_r
                : (araddr == PERIOD_OFS) ? period_r
                : (araddr == CHCTL_OFS) ? WIDTH'({ch1_r, ch0_r, cap_mode_r})
                : (araddr == CHCMP_OFS) ? ccr_r
                : (araddr == VEC_OFS) ? WIDTH'(vec_w) : '0;
  logic rd_hit;
  assign rd_hit = araddr == CTRL_OFS || araddr == CNT_OFS || araddr == PERIOD_OFS
               || araddr == CHCTL_OFS || araddr == CHCMP_OFS || araddr == VEC_OFS;

  // Bus handshakes
  assign awready = !aw_hold_r && !bvalid_r;
  assign wready = !w_hold_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_wr)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
        bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= 32'(rd_val);
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
      rvalid_r <= 1'b0;
  end

  // Counter control
  mode_t mode;
  logic clr, counting, at_top, wrap_ev, ch0_ev, ch1_ev, cap_ev, full_ctrl;
  logic [WIDTH-1:0] top;
  assign mode = mode_t'(ctrl_r[MODE_LSB +: 2]);
  assign clr = wr_ctrl && ctrl_wv[CLR_BIT];
  assign full_ctrl = wr_ctrl && wstrb_r == STRB_FULL;
  assign top = (mode == MODE_UP) ? period_r : '1;
  assign counting = (mode == MODE_UP || mode == MODE_CONT) && tk.tick;
  assign at_top = cnt_r >= top;

  always_comb
  begin
    cnt_nxt = cnt_r;
    case (mode)
      MODE_UP, MODE_CONT:
        if (tk.tick)
          cnt_nxt = at_top ? '0 : cnt_r + 1'b1;
      default:
        cnt_nxt = cnt_r;
    endcase
    if (clr)
      cnt_nxt = '0;
  end

  // Only a counted wrap flags; a clear never does
  assign wrap_ev = counting && !clr && at_top;
  assign ch0_ev = counting && !clr && cnt_nxt == period_r;
  // Equality is judged on the new count, so a +1 edit before the tick still hits
  assign ch1_ev = counting && !clr && !cap_mode_r && cnt_nxt == ccr_r;
  assign cap_ev = cap_mode_r && cap_sync_r[1] && !cap_sync_r[2];

  assign tk.sel = ctrl_r[SRC_LSB +: 2];
  assign tk.div = ctrl_r[DIV_LSB +: 2];
  assign tk.clr = clr || power_up_clear;

  tick_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .src_pins({inverted_ext_clock, subsystem_clock, aux_clock, ext_timer_clock}),
    .tk(tk)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cap_sync_r <= 3'h0;
    else
      cap_sync_r <= {cap_sync_r[1:0], capture_in};
  end

  // Flag clears: software write of zero, full control write, or vector read
  logic ovf_clr, ch0_clr, ch1_clr;
  assign ovf_clr = full_ctrl || (wr_ctrl && !ctrl_wv[OVF_BIT])
                || (rd_vec && vec_w == VEC_OVF);
  assign ch0_clr = full_ctrl || (wr_chctl && !chctl_wv[CH0_FLAG_BIT])
                || (rd_vec && vec_w == VEC_CH0);
  assign ch1_clr = full_ctrl || (wr_chctl && !chctl_wv[CH1_FLAG_BIT])
                || (rd_vec && vec_w == VEC_CH1);

  // Watchdog clear acts like reset on every timer register, whatever the channel is doing
  always_ff @(posedge aclk)
  begin
    if (!aresetn || power_up_clear)
    begin
      ctrl_r <= 8'h00;
      ovf_r <= 1'b0;
      ch0_r <= 1'b0;
      ch1_r <= 1'b0;
      cnt_r <= '0;
      period_r <= '0;
      ccr_r <= '0;
      cap_mode_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= {1'b0, 1'b0, ctrl_wv[5:0]};
      ovf_r <= wrap_ev || (ovf_r && !ovf_clr);
      ch0_r <= ch0_ev || (ch0_r && !ch0_clr);
      ch1_r <= ch1_ev || cap_ev || (ch1_r && !ch1_clr);
      cnt_r <= cnt_nxt;
      if (wr_period)
        period_r <= merge(period_r, wdata_r, wstrb_r);
      if (cap_ev)
        ccr_r <= cnt_r;
      else if (wr_chcmp)
        ccr_r <= merge(ccr_r, wdata_r, wstrb_r);
      if (wr_chctl)
        cap_mode_r <= chctl_wv[CAP_BIT];
    end
  end

  assign counter_value = cnt_r;
endmodule : up_mode_timer_counter

`default_nettype wire

/* sim/up_mode_timer_counter_assertions.sv */
// Purpose: Port-level checks of the timer block
// Assumes: One clock, reset synchronous and active low
// Notes: Bound into every timer instance
`timescale 1ns/1ps
`default_nettype none
module tmr_chk
  import tmr_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_up_clear,
  // Bus handshakes
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Counter
  input wire logic [WIDTH-1:0] counter_value
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  chk_ar_block: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  chk_w_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_slverr_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == '0)
    else $error("refused read returned data");
  chk_puc_zero: assert property (power_up_clear |=> counter_value == '0)
    else $error("counter not zero after power-up clear");
  chk_step_one: assert property ($changed(counter_value) |->
    counter_value == $past(counter_value) + 1'h1 || counter_value == '0)
    else $error("counter jumped");
  // Pins hold each level two cycles, so ticks are at least four cycles apart
  chk_tick_gap: assert property ($changed(counter_value) && counter_value != '0 |=>
    (counter_value == $past(counter_value) || counter_value == '0) [*3])
    else $error("counter ticked too soon");
  chk_rst_idle: assert property (disable iff (1'h0)
    !aresetn |=> !bvalid && !rvalid && counter_value == '0)
    else $error("outputs not idle in reset");
  cov_write: cover property (bvalid && bready);
  cov_refused: cover property (rvalid && rresp == RESP_SLVERR);
  cov_wrap: cover property ($changed(counter_value) && counter_value == '0);
  cov_puc: cover property (power_up_clear);
endmodule : tmr_chk
bind up_mode_timer_counter tmr_chk #(.WIDTH(WIDTH)) i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .power_up_clear(power_up_clear),
  .awready(awready),
  .wready(wready),
  .bvalid(bvalid),
  .bready(bready),
  .arready(arready),
  .rvalid(rvalid),
  .rready(rready),
  .rdata(rdata),
  .rresp(rresp),
  .counter_value(counter_value)
);
`default_nettype wire

/* sim/up_mode_timer_counter_bench.sv */
// Purpose: Self-checking bench of the timer block
// Assumes: Source pins toggle with half periods of 3, 4, 5 and 6 cycles
// Notes: Count checks allow one tick of slack for pin phase
`timescale 1ns/1ps
`default_nettype none
module up_mode_timer_counter_bench;
  import tmr_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, power_up_clear = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0] wstrb = 4'h0;
  logic ext_timer_clock = 1'h0, aux_clock = 1'h0, subsystem_clock = 1'h0;
  logic inverted_ext_clock = 1'h0, capture_in = 1'h0;
  logic [1:0] r;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] counter_value;
  int bad_count = 0, n_checks = 0, tk = 0, w, e, p, c;
  int h[4] = '{3, 4, 5, 6};
  up_mode_timer_counter #(.WIDTH(16)) i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_up_clear(power_up_clear),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .inverted_ext_clock(inverted_ext_clock),
    .subsystem_clock(subsystem_clock),
    .aux_clock(aux_clock),
    .ext_timer_clock(ext_timer_clock),
    .capture_in(capture_in),
    .counter_value(counter_value)
  );
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    tk <= tk + 1;
    ext_timer_clock <= tk % 6 < 3;
    aux_clock <= tk % 8 < 4;
    subsystem_clock <= tk % 10 < 5;
    inverted_ext_clock <= tk % 12 < 6;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    logic [1:0] br;
    n = 0;
    tb = 1'h0;
    br = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= STRB_FULL;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb && n < 100)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      n++;
    end
    bready <= 1'h0;
    if (!tb) chk(1'h0, 1'h1);
    chk(br, RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr && n < 100)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
      n++;
    end
    rready <= 1'h0;
    if (!tr) chk(1'h0, 1'h1);
  endtask : rd
  task automatic wcnt(input int v);
    int n;
    n = 0;
    while (counter_value !== 16'(v) && n < 3000)
    begin
      @(negedge aclk);
      n++;
    end
    if (n == 3000) chk(counter_value, v);
  endtask : wcnt
  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h22A2));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL_OFS);
    chk(d, 32'h0);
    rd(CNT_OFS);
    chk(d, 32'h0);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    wr(PERIOD_OFS, 32'hFFFF);
    // Every source and every divider, two dividers per source: up mode plus clear
    for (int i = 0; i < 8; i++)
    begin
      w = 200 + $urandom % 200;
      wr(CTRL_OFS, i % 4 | (i / 2) << 2 | 32'h50);
      repeat (w) @(posedge aclk);
      rd(CNT_OFS);
      e = w / ((2 * h[i % 4]) << (i / 2));
      chk(d + 1 >= e && d <= e + 1, 1'h1);
    end
    // Divide by 8 on the 6-cycle pin: the first count needs eight edges, over 40 cycles
    wr(CTRL_OFS, 32'h5C);
    repeat (30) @(posedge aclk);
    rd(CNT_OFS);
    chk(d, 32'h0);
    p = 2 + $urandom % 4;
    wr(PERIOD_OFS, p);
    wr(CTRL_OFS, 32'h51);
    wcnt(p);
    wr(CTRL_OFS, 32'h0);
    rd(CNT_OFS);
    chk(d, p);
    wr(CTRL_OFS, 32'h40);
    rd(CNT_OFS);
    chk(d, 32'h0);
    wr(CTRL_OFS, 32'h11);
    wcnt(1);
    repeat (2) @(posedge aclk);
    rd(CTRL_OFS);
    chk(d[OVF_BIT], 1'h0);
    wcnt(0);
    rd(CTRL_OFS);
    chk(d[OVF_BIT], 1'h1);
    rd(CHCTL_OFS);
    chk(d[CH0_FLAG_BIT], 1'h1);
    rd(VEC_OFS);
    chk(d, VEC_CH0);
    // Overflow bit written as one, so only the full-word rule can clear it
    wr(CTRL_OFS, 32'h80);
    rd(VEC_OFS);
    chk(d, 32'h0);
    c = 3 + $urandom % 5;
    wr(PERIOD_OFS, 32'h40);
    wr(CHCMP_OFS, c);
    wr(CTRL_OFS, 32'h55);
    wcnt(c);
    wr(CHCMP_OFS, c + 1);
    wr(CHCTL_OFS, 32'h0);
    wcnt(c + 1);
    repeat (2) @(posedge aclk);
    rd(CHCTL_OFS);
    chk(d[CH1_FLAG_BIT], 1'h1);
    wr(CHCTL_OFS, 32'h1);
    wcnt(c + 2);
    wcnt(c + 1);
    repeat (2) @(posedge aclk);
    rd(CHCTL_OFS);
    chk(d[CH1_FLAG_BIT], 1'h0);
    capture_in <= 1'h1;
    repeat (6) @(posedge aclk);
    capture_in <= 1'h0;
    rd(CHCTL_OFS);
    chk(d[CH1_FLAG_BIT], 1'h1);
    power_up_clear <= 1'h1;
    @(posedge aclk);
    power_up_clear <= 1'h0;
    rd(CTRL_OFS);
    chk(d, 32'h0);
    rd(VEC_OFS);
    chk(d, 32'h0);
    rd(CNT_OFS);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule : up_mode_timer_counter_bench
`default_nettype wire
